// ### rtl/asof_regs.svh
// asof_regs.svh: offsets, field positions, reset values, codes, counts
// assumes: included once by the formatter, after the package is compiled
`ifndef ASOF_REGS_SVH
`define ASOF_REGS_SVH
// --------------------------------------------------------------
// register offsets (13-bit control-port address)
// --------------------------------------------------------------
`define ASOF_OFS_MODE 13'h000D
`define ASOF_OFS_OUTFMT 13'h0014
`define ASOF_OFS_PHASE 13'h0016
`define ASOF_OFS_UP1L 13'h0019
`define ASOF_OFS_UP1H 13'h001A
`define ASOF_OFS_UP2L 13'h001B
`define ASOF_OFS_UP2H 13'h001C
`define ASOF_OFS_WORD 13'h0021
`define ASOF_OFS_STRAP 13'h0030
// --------------------------------------------------------------
// field positions
// --------------------------------------------------------------
`define ASOF_FMT_TWOS 0
`define ASOF_FMT_INV 2
`define ASOF_WORD_LSB 2
// --------------------------------------------------------------
// reset values
// --------------------------------------------------------------
`define ASOF_PHASE_RST 4'h3
`define ASOF_LEN_RST 2'h0
`define ASOF_USER_RST 8'h00
`define ASOF_MODE_RST 4'h0
// --------------------------------------------------------------
// word length codes
// --------------------------------------------------------------
`define ASOF_LEN_12 2'h0
`define ASOF_LEN_8 2'h1
`define ASOF_LEN_10 2'h2
`define ASOF_LEN_14 2'h3
// --------------------------------------------------------------
// test mode codes
// --------------------------------------------------------------
`define ASOF_TM_OFF 4'h0
`define ASOF_TM_MID 4'h1
`define ASOF_TM_FULLP 4'h2
`define ASOF_TM_FULLN 4'h3
`define ASOF_TM_CHECK 4'h4
`define ASOF_TM_PNL 4'h5
`define ASOF_TM_PNS 4'h6
`define ASOF_TM_WTOG 4'h7
`define ASOF_TM_USER 4'h8
`define ASOF_TM_BTOG 4'h9
`define ASOF_TM_SYNC 4'hA
`define ASOF_TM_ONEB 4'hB
`define ASOF_TM_MIX 4'hC
// --------------------------------------------------------------
// pn generators, link timing and control port counts
// --------------------------------------------------------------
`define ASOF_PN9_SEED 9'h0DF
`define ASOF_PN9_TAP 4
`define ASOF_PN23_SEED 23'h29B80A
`define ASOF_PN23_TAP 17
`define ASOF_TICK_LAST 3'h5
`define ASOF_PHASE_STEPS 4'hC
`define ASOF_HALF_BCLK 4'h6
`define ASOF_SP_INSTR_LAST 5'h0F
`define ASOF_SP_BYTE_LAST 5'h07
`define ASOF_SP_RD_END 5'h08
`endif

// ### rtl/asof_pkg.sv
// asof_pkg: types shared by the output formatter
// assumes: compiled before the formatter
`default_nettype none
package asof_pkg;
  typedef logic [3:0] asof_mode_type;
  typedef logic [13:0] asof_word_type;
  typedef logic [15:0] asof_frame_type;
  typedef enum logic [1:0] {SP_INSTR, SP_WRITE, SP_READ, SP_DONE}
    asof_sp_state_type;
endpackage : asof_pkg
`default_nettype wire

// ### rtl/asof_formatter.sv
// asof_formatter: serial lane formatter, test patterns, straps, control port
// assumes: LINK_CLK_I ticks six times per data bit; samples on CLK_SYS_I
`include "asof_regs.svh"
`default_nettype none
module asof_formatter import asof_pkg::*; (
  // system clock and reset
  input wire logic CLK_SYS_I,
  input wire logic RESET_N_I,
  // link clock
  input wire logic LINK_CLK_I,
  // converter samples
  input wire logic [11:0] SAMPLE0_I,
  input wire logic [11:0] SAMPLE1_I,
  input wire logic [11:0] SAMPLE2_I,
  input wire logic [11:0] SAMPLE3_I,
  input wire logic SAMPLE_VALID_I,
  // control port pins
  input wire logic SERIAL_SELECT_N_I,
  input wire logic SERIAL_CLK_I,
  input wire logic SERIAL_DATA_I,
  output logic SERIAL_DATA_O,
  output logic SERIAL_DATA_OE_O,
  // straps
  input wire logic REDUCED_SWING_STRAP_I,
  input wire logic TEST_PATTERN_STRAP_I,
  // link outputs
  output logic [3:0] LANE_O,
  output logic BIT_CLOCK_OUT_O,
  output logic FRAME_CLOCK_OUT_O,
  output logic REDUCED_SWING_O
);
  // --------------------------------------------------------------
  // functions
  // --------------------------------------------------------------
  function automatic logic [4:0] len_bits(input logic [1:0] lc);
    case (lc)
      `ASOF_LEN_8: len_bits = 5'h08;
      `ASOF_LEN_10: len_bits = 5'h0A;
      `ASOF_LEN_14: len_bits = 5'h0E;
      default: len_bits = 5'h0C;
    endcase
  endfunction : len_bits

  function automatic asof_word_type fit(input asof_word_type v,
                                        input logic [4:0] n);
    fit = v >> (5'h0E - n);
  endfunction : fit

  function automatic asof_word_type lmask(input logic [4:0] n);
    lmask = 14'((15'h0001 << n) - 15'h0001);
  endfunction : lmask

  function automatic asof_frame_type mk_frame(input asof_word_type v,
      input logic [4:0] n, input logic lsb);
    mk_frame = '0;
    for (int i = 0; i < 14; i++) begin
      if (i < int'(n)) begin
        mk_frame[15-i] = lsb ? v[i] : v[4'(int'(n) - 1 - i)];
      end
    end
  endfunction : mk_frame

  // twelve output bits, then the state after them
  function automatic logic [20:0] pn9_step(input logic [8:0] s);
    logic [8:0] t;
    logic [11:0] w;
    t = s;
    w = '0;
    for (int i = 0; i < 12; i++) begin
      w = {w[10:0], t[7]};
      t = {t[7:0], t[8] ^ t[`ASOF_PN9_TAP]};
    end
    pn9_step = {w, t};
  endfunction : pn9_step

  function automatic logic [34:0] pn23_step(input logic [22:0] s);
    logic [22:0] t;
    logic [11:0] w;
    t = s;
    w = '0;
    for (int i = 0; i < 12; i++) begin
      w = {w[10:0], ~t[21]};
      t = {t[21:0], t[22] ^ t[`ASOF_PN23_TAP]};
    end
    pn23_step = {w, t};
  endfunction : pn23_step

  // --------------------------------------------------------------
  // pin synchronisers and straps
  // --------------------------------------------------------------
  logic [2:0] sck_s;
  logic [1:0] sdi_s, sel_s;
  logic [1:0] rsw_s, tps_s;
  logic [1:0] strap_cnt_reg;
  logic strap_rsw_reg, strap_tp_reg, strap_sel_reg;
  always_ff @(posedge CLK_SYS_I) begin
    sck_s <= {sck_s[1:0], SERIAL_CLK_I};
    sdi_s <= {sdi_s[0], SERIAL_DATA_I};
    sel_s <= {sel_s[0], SERIAL_SELECT_N_I};
    rsw_s <= {rsw_s[0], REDUCED_SWING_STRAP_I};
    tps_s <= {tps_s[0], TEST_PATTERN_STRAP_I};
  end
  // straps caught once, after the synchronisers have filled
  always_ff @(posedge CLK_SYS_I) begin
    if (!RESET_N_I) begin
      strap_cnt_reg <= 2'h0;
      strap_rsw_reg <= 1'b0;
      strap_tp_reg <= 1'b0;
      strap_sel_reg <= 1'b0;
    end else if (strap_cnt_reg != 2'h3) begin
      strap_cnt_reg <= strap_cnt_reg + 2'h1;
      if (strap_cnt_reg == 2'h2) begin
        strap_sel_reg <= sel_s[1];
        strap_rsw_reg <= rsw_s[1] & sel_s[1];
        strap_tp_reg <= tps_s[1] & sel_s[1];
      end
    end
  end
  assign REDUCED_SWING_O = strap_rsw_reg;

  // --------------------------------------------------------------
  // control port: 16-bit instruction, one data byte
  // --------------------------------------------------------------
  asof_sp_state_type sp_state_reg;
  logic [4:0] sp_cnt_reg;
  logic [15:0] sp_shift_reg;
  logic [12:0] sp_addr_reg;
  logic sp_oe_reg, sp_sdo_reg;
  logic [7:0] rd_byte, wr_byte;
  logic sck_rise, sck_fall, sp_wr;
  assign sck_rise = sck_s[1] & ~sck_s[2];
  assign sck_fall = ~sck_s[1] & sck_s[2];
  assign wr_byte = {sp_shift_reg[6:0], sdi_s[1]};
  assign sp_wr = (sp_state_reg == SP_WRITE) && sck_rise &&
                 (sp_cnt_reg == `ASOF_SP_BYTE_LAST);
  always_ff @(posedge CLK_SYS_I) begin
    if (!RESET_N_I || sel_s[1]) begin
      sp_state_reg <= SP_INSTR;
      sp_cnt_reg <= '0;
      sp_oe_reg <= 1'b0;
      sp_sdo_reg <= 1'b0;
    end else begin
      case (sp_state_reg)
        SP_INSTR: if (sck_rise) begin
          sp_shift_reg <= {sp_shift_reg[14:0], sdi_s[1]};
          sp_cnt_reg <= sp_cnt_reg + 5'h01;
          if (sp_cnt_reg == `ASOF_SP_INSTR_LAST) begin
            sp_cnt_reg <= '0;
            sp_addr_reg <= {sp_shift_reg[11:0], sdi_s[1]};
            sp_state_reg <= sp_shift_reg[14] ? SP_READ : SP_WRITE;
          end
        end
        SP_WRITE: if (sck_rise) begin
          sp_shift_reg <= {sp_shift_reg[14:0], sdi_s[1]};
          sp_cnt_reg <= sp_cnt_reg + 5'h01;
          if (sp_cnt_reg == `ASOF_SP_BYTE_LAST) begin
            sp_state_reg <= SP_DONE;
          end
        end
        SP_READ: if (sck_fall) begin
          sp_oe_reg <= (sp_cnt_reg != `ASOF_SP_RD_END);
          sp_sdo_reg <= rd_byte[3'(`ASOF_SP_BYTE_LAST - sp_cnt_reg)];
          sp_cnt_reg <= sp_cnt_reg + 5'h01;
          if (sp_cnt_reg == `ASOF_SP_RD_END) begin
            sp_state_reg <= SP_DONE;
          end
        end
        SP_DONE: sp_oe_reg <= 1'b0;
        default: sp_state_reg <= SP_INSTR;
      endcase
    end
  end
  assign SERIAL_DATA_O = sp_sdo_reg;
  assign SERIAL_DATA_OE_O = sp_oe_reg;

  // --------------------------------------------------------------
  // registers
  // --------------------------------------------------------------
  logic [7:0] up1l_reg, up1h_reg, up2l_reg, up2h_reg;
  asof_mode_type mode_reg;
  logic twos_reg, inv_reg, lsb_reg;
  logic [1:0] len_reg;
  logic [3:0] phase_reg;
  always_ff @(posedge CLK_SYS_I) begin
    if (!RESET_N_I) begin
      up1l_reg <= `ASOF_USER_RST;
      up1h_reg <= `ASOF_USER_RST;
      up2l_reg <= `ASOF_USER_RST;
      up2h_reg <= `ASOF_USER_RST;
      mode_reg <= `ASOF_MODE_RST;
      twos_reg <= 1'b0;
      inv_reg <= 1'b0;
      lsb_reg <= 1'b0;
      len_reg <= `ASOF_LEN_RST;
      phase_reg <= `ASOF_PHASE_RST;
    end else if (sp_wr) begin
      case (sp_addr_reg)
        `ASOF_OFS_UP1L: up1l_reg <= wr_byte;
        `ASOF_OFS_UP1H: up1h_reg <= wr_byte;
        `ASOF_OFS_UP2L: up2l_reg <= wr_byte;
        `ASOF_OFS_UP2H: up2h_reg <= wr_byte;
        `ASOF_OFS_MODE: mode_reg <= wr_byte[3:0];
        `ASOF_OFS_OUTFMT: begin
          twos_reg <= wr_byte[`ASOF_FMT_TWOS];
          inv_reg <= wr_byte[`ASOF_FMT_INV];
        end
        `ASOF_OFS_WORD: begin
          len_reg <= wr_byte[1:0];
          lsb_reg <= wr_byte[`ASOF_WORD_LSB];
        end
        `ASOF_OFS_PHASE: if (wr_byte < 8'(`ASOF_PHASE_STEPS)) begin
          phase_reg <= wr_byte[3:0];
        end
        default: ;
      endcase
    end
  end
  assign rd_byte =
    (sp_addr_reg == `ASOF_OFS_UP1L) ? up1l_reg :
    (sp_addr_reg == `ASOF_OFS_UP1H) ? up1h_reg :
    (sp_addr_reg == `ASOF_OFS_UP2L) ? up2l_reg :
    (sp_addr_reg == `ASOF_OFS_UP2H) ? up2h_reg :
    (sp_addr_reg == `ASOF_OFS_MODE) ? {4'h0, mode_reg} :
    (sp_addr_reg == `ASOF_OFS_OUTFMT) ? {5'h00, inv_reg, 1'b0, twos_reg} :
    (sp_addr_reg == `ASOF_OFS_WORD) ? {5'h00, lsb_reg, len_reg} :
    (sp_addr_reg == `ASOF_OFS_PHASE) ? {4'h0, phase_reg} :
    (sp_addr_reg == `ASOF_OFS_STRAP) ?
      {5'h00, strap_tp_reg, strap_rsw_reg, strap_sel_reg} : 8'h00;

  // --------------------------------------------------------------
  // patterns
  // --------------------------------------------------------------
  logic req_reg, word_sel_reg, busy, load, l_ack_reg;
  logic [1:0] ack_s;
  logic [8:0] pn9_reg;
  logic [22:0] pn23_reg;
  logic [20:0] pn9_nx;
  logic [34:0] pn23_nx;
  logic pn_sel, mode_off, pat_fmt;
  logic [4:0] n, flen;
  asof_word_type pat_v, sync_v, mix_v;
  assign pn9_nx = pn9_step(pn9_reg);
  assign pn23_nx = pn23_step(pn23_reg);
  assign pn_sel = (mode_reg == `ASOF_TM_PNS) || (mode_reg == `ASOF_TM_PNL);
  assign mode_off = (mode_reg == `ASOF_TM_OFF) || (mode_reg > `ASOF_TM_MIX);
  // pn words only exist at 12 bits
  assign n = len_bits(pn_sel ? `ASOF_LEN_12 : len_reg);
  assign flen = (n == 5'h0E) ? 5'h10 : n;
  assign sync_v = lmask(n >> 1);
  assign mix_v = (n == 5'h08) ? 14'h00A3 : (n == 5'h0A) ? 14'h0263 :
                 (n == 5'h0E) ? 14'h2867 : 14'h0A33;
  always_comb begin
    pat_v = '0;
    pat_fmt = 1'b0;
    case (mode_reg)
      `ASOF_TM_MID: begin
        pat_v = fit(14'h2000, n);
        pat_fmt = 1'b1;
      end
      `ASOF_TM_FULLP: begin
        pat_v = fit(14'h3FFF, n);
        pat_fmt = 1'b1;
      end
      `ASOF_TM_FULLN: pat_fmt = 1'b1;
      `ASOF_TM_CHECK: pat_v = fit(word_sel_reg ? 14'h1555 : 14'h2AAA, n);
      `ASOF_TM_PNL: begin
        pat_v = {2'b00, pn23_nx[34:23]};
        pat_fmt = 1'b1;
      end
      `ASOF_TM_PNS: begin
        pat_v = {2'b00, pn9_nx[20:9]};
        pat_fmt = 1'b1;
      end
      `ASOF_TM_WTOG: pat_v = word_sel_reg ? 14'h0000 : fit(14'h3FFF, n);
      `ASOF_TM_USER: pat_v = lmask(n) & (word_sel_reg ?
        {up2h_reg[5:0], up2l_reg} : {up1h_reg[5:0], up1l_reg});
      `ASOF_TM_BTOG: pat_v = fit(14'h2AAA, n);
      `ASOF_TM_SYNC: pat_v = sync_v;
      `ASOF_TM_ONEB: pat_v = fit(14'h2000, n);
      `ASOF_TM_MIX: pat_v = mix_v;
      default: ;
    endcase
  end

  // --------------------------------------------------------------
  // channel words and hand-off to the link
  // --------------------------------------------------------------
  logic [11:0] smp [4];
  asof_frame_type frame [4];
  asof_frame_type hold_frame [4];
  logic [4:0] hold_len;
  logic [3:0] hold_phase;
  logic hold_inv;
  assign smp[0] = SAMPLE0_I;
  assign smp[1] = SAMPLE1_I;
  assign smp[2] = SAMPLE2_I;
  assign smp[3] = SAMPLE3_I;
  for (genvar c = 0; c < 4; c++) begin : g_ch
    asof_word_type raw, val;
    logic fmt_on;
    assign raw = mode_off ? fit({smp[c], 2'b00}, n) : pat_v;
    assign fmt_on = twos_reg && (mode_off || pat_fmt);
    assign val = strap_tp_reg ? fit(14'h2000, n) :
                 raw ^ (fmt_on ? (lmask(n) & ~lmask(n - 5'h01)) : 14'h0);
    assign frame[c] = mk_frame(val, n, lsb_reg);
  end
  // a sample arriving while the previous word is still in flight is dropped
  assign busy = req_reg ^ ack_s[1];
  assign load = SAMPLE_VALID_I && !busy;
  always_ff @(posedge CLK_SYS_I) begin
    if (!RESET_N_I) begin
      ack_s <= 2'b00;
      req_reg <= 1'b0;
      word_sel_reg <= 1'b0;
    end else begin
      ack_s <= {ack_s[0], l_ack_reg};
      req_reg <= req_reg ^ load;
      word_sel_reg <= mode_off ? 1'b0 : word_sel_reg ^ load;
    end
  end
  // pn held at seed while not selected, so selection starts at seed
  always_ff @(posedge CLK_SYS_I) begin
    if (!RESET_N_I || mode_reg != `ASOF_TM_PNS) begin
      pn9_reg <= `ASOF_PN9_SEED;
    end else if (load) begin
      pn9_reg <= pn9_nx[8:0];
    end
  end
  always_ff @(posedge CLK_SYS_I) begin
    if (!RESET_N_I || mode_reg != `ASOF_TM_PNL) begin
      pn23_reg <= `ASOF_PN23_SEED;
    end else if (load) begin
      pn23_reg <= pn23_nx[22:0];
    end
  end
  always_ff @(posedge CLK_SYS_I) begin
    if (load) begin
      hold_frame <= frame;
      hold_len <= flen;
      hold_phase <= phase_reg;
      hold_inv <= inv_reg;
    end
  end

  // --------------------------------------------------------------
  // link domain
  // --------------------------------------------------------------
  logic [1:0] lrst_s;
  logic [2:0] lreq_s;
  logic lrst_n, l_new, l_end_bit, l_end_frame, l_inv, bco_nx;
  logic [2:0] tick_reg;
  logic [4:0] bit_reg, l_len, p_len;
  logic [3:0] l_phase, p_phase, pos12, diff;
  logic p_inv;
  asof_frame_type p_frame [4];
  asof_frame_type l_frame [4];
  assign lrst_n = lrst_s[1];
  assign l_new = lreq_s[1] ^ lreq_s[2];
  assign l_end_bit = (tick_reg == `ASOF_TICK_LAST);
  assign l_end_frame = l_end_bit && (bit_reg == l_len - 5'h01);
  assign pos12 = (bit_reg[0] ? `ASOF_HALF_BCLK : 4'h0) + {1'b0, tick_reg};
  assign diff = (pos12 >= l_phase) ? pos12 - l_phase :
                pos12 + `ASOF_PHASE_STEPS - l_phase;
  assign bco_nx = (diff < `ASOF_HALF_BCLK);
  always_ff @(posedge LINK_CLK_I) begin
    lrst_s <= {lrst_s[0], RESET_N_I};
  end
  always_ff @(posedge LINK_CLK_I) begin
    if (!lrst_n) begin
      lreq_s <= 3'h0;
      l_ack_reg <= 1'b0;
      p_len <= 5'h0C;
      p_phase <= `ASOF_PHASE_RST;
      p_inv <= 1'b0;
      p_frame <= '{default: '0};
    end else begin
      lreq_s <= {lreq_s[1:0], req_reg};
      if (l_new) begin
        l_ack_reg <= lreq_s[1];
        p_frame <= hold_frame;
        p_len <= hold_len;
        p_phase <= hold_phase;
        p_inv <= hold_inv;
      end
    end
  end
  // settings change only between frames; the last word repeats if none new
  always_ff @(posedge LINK_CLK_I) begin
    if (!lrst_n) begin
      tick_reg <= 3'h0;
      bit_reg <= 5'h00;
      l_len <= 5'h0C;
      l_phase <= `ASOF_PHASE_RST;
      l_inv <= 1'b0;
      l_frame <= '{default: '0};
    end else begin
      tick_reg <= l_end_bit ? 3'h0 : tick_reg + 3'h1;
      if (l_end_bit) begin
        bit_reg <= l_end_frame ? 5'h00 : bit_reg + 5'h01;
      end
      if (l_end_frame) begin
        l_frame <= p_frame;
        l_len <= p_len;
        l_phase <= p_phase;
        l_inv <= p_inv;
      end
    end
  end
  always_ff @(posedge LINK_CLK_I) begin
    if (!lrst_n) begin
      BIT_CLOCK_OUT_O <= 1'b0;
      FRAME_CLOCK_OUT_O <= 1'b0;
      LANE_O <= 4'h0;
    end else begin
      BIT_CLOCK_OUT_O <= bco_nx;
      FRAME_CLOCK_OUT_O <= (bit_reg < (l_len >> 1));
      for (int c = 0; c < 4; c++) begin
        LANE_O[c] <= l_frame[c][4'(5'h0F - bit_reg)] ^ l_inv;
      end
    end
  end

  // --------------------------------------------------------------
  // checks
  // --------------------------------------------------------------
  sequence s_frame_open;
    !FRAME_CLOCK_OUT_O ##1 FRAME_CLOCK_OUT_O;
  endsequence
  chk_pn_reseed: assert property (@(posedge CLK_SYS_I)
    disable iff (!RESET_N_I)
    $rose(mode_reg == `ASOF_TM_PNS) |-> pn9_reg == `ASOF_PN9_SEED)
    else $error("short pn not at seed on selection");
  chk_word_alt: assert property (@(posedge CLK_SYS_I)
    disable iff (!RESET_N_I)
    (load && mode_reg == `ASOF_TM_CHECK) |=> $changed(word_sel_reg))
    else $error("two-word pattern did not alternate");
  chk_len_stuff: assert property (@(posedge CLK_SYS_I)
    disable iff (!RESET_N_I)
    (load && n == 5'h0E) |=> hold_len == 5'h10 && hold_frame[0][1:0] == 2'b00)
    else $error("14-bit frame not stuffed");
  chk_strap_word: assert property (@(posedge CLK_SYS_I)
    disable iff (!RESET_N_I)
    (load && strap_tp_reg && !lsb_reg && n == 5'h0C)
    |=> hold_frame[3][15:4] == 12'h800)
    else $error("strap pattern word wrong");
  chk_lsb_order: assert property (@(posedge CLK_SYS_I)
    disable iff (!RESET_N_I)
    (load && lsb_reg && n == 5'h0C && mode_reg == `ASOF_TM_MIX)
    |=> hold_frame[1][15:4] == 12'hCC5)
    else $error("lsb-first order wrong");
  chk_select_idle: assert property (@(posedge CLK_SYS_I)
    disable iff (!RESET_N_I)
    sel_s[1] |=> sp_state_reg == SP_INSTR && !SERIAL_DATA_OE_O)
    else $error("control port active while deselected");
  chk_bco_phase: assert property (@(posedge LINK_CLK_I)
    disable iff (!lrst_n)
    (pos12 == l_phase) |=> BIT_CLOCK_OUT_O)
    else $error("bit clock edge not at programmed phase");
  // frame clock is registered one tick behind the bit counter
  chk_fco_start: assert property (@(posedge LINK_CLK_I)
    disable iff (!lrst_n)
    l_end_frame |=> s_frame_open)
    else $error("frame clock not at word start");
  chk_bclk_rate: assert property (@(posedge LINK_CLK_I)
    disable iff (!lrst_n)
    ($rose(BIT_CLOCK_OUT_O) && l_phase < 4'h6) |-> ##6 $fell(BIT_CLOCK_OUT_O))
    else $error("bit clock half period not six ticks");
endmodule : asof_formatter
`default_nettype wire

// ### sim/asof_rx_model.sv
// asof_rx_model: ddr receiver rebuilding lane words per frame
// assumes: default bit clock phase centres both edges in each bit
`default_nettype none
module asof_rx_model (
  // link pins
  input wire logic bclk_i,
  input wire logic fclk_i,
  input wire logic [3:0] lane_i,
  // words of the last whole frame, right justified
  output logic [63:0] words_o,
  output logic [4:0] nbits_o,
  output logic [15:0] frames_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [63:0] sh_reg = '0;
  logic [4:0] n_reg = '0;
  logic f_reg = 1'b0;
  initial begin
    words_o = '0;
    nbits_o = '0;
    frames_o = '0;
  end
  // capture on both bit clock edges
  // a frame clock rise marks a new word
  always @(bclk_i) begin
    if (fclk_i && !f_reg) begin
      words_o = sh_reg;
      nbits_o = n_reg;
      frames_o = frames_o + 16'h1;
      sh_reg = '0;
      n_reg = '0;
    end
    for (int i = 0; i < 4; i++) begin
      sh_reg[i*16 +: 16] = {sh_reg[i*16 +: 15], lane_i[i]};
    end
    n_reg = n_reg + 5'h1;
    f_reg = fclk_i;
  end
endmodule : asof_rx_model
`default_nettype wire

// ### sim/tb_top.sv
// tb_top: formatter bench, serial port tasks and lane word checks
// assumes: asof_rx_model rebuilds words; lanes repeat the held word
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, lclk = 1'b0, rst_n = 1'b0, sv = 1'b0;
  logic sel_n = 1'b1, sclk = 1'b0, sdi = 1'b0, rs = 1'b1, tp = 1'b1;
  logic [11:0] s0 = 12'h123, s1 = 12'h456, s2 = 12'h789, s3 = 12'hABC;
  logic sdo, oe, bco, frame_clock_out, rso;
  logic [3:0] lane;
  logic [63:0] words;
  logic [4:0] nb;
  logic [15:0] fr;
  int n_fail = 0, num_checks = 0;
  // shared data pin: device drives only while oe is high
  wire logic sdio = oe ? sdo : sdi;
  always #12.5 clk = ~clk;
  always #6 lclk = ~lclk;
  asof_formatter dut (
    .CLK_SYS_I(clk), .RESET_N_I(rst_n), .LINK_CLK_I(lclk),
    .SAMPLE0_I(s0), .SAMPLE1_I(s1), .SAMPLE2_I(s2), .SAMPLE3_I(s3),
    .SAMPLE_VALID_I(sv), .SERIAL_SELECT_N_I(sel_n),
    .SERIAL_CLK_I(sclk), .SERIAL_DATA_I(sdio), .SERIAL_DATA_O(sdo),
    .SERIAL_DATA_OE_O(oe), .REDUCED_SWING_STRAP_I(rs),
    .TEST_PATTERN_STRAP_I(tp), .LANE_O(lane), .BIT_CLOCK_OUT_O(bco),
    .FRAME_CLOCK_OUT_O(frame_clock_out), .REDUCED_SWING_O(rso));
  asof_rx_model rx (.bclk_i(bco), .fclk_i(frame_clock_out), .lane_i(lane),
    .words_o(words), .nbits_o(nb), .frames_o(fr));
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_sim
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  task automatic chk(input string s, input logic [63:0] e,
      input logic [63:0] g);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("Error %s expected %h seen %h", s, e, g);
    end
  endtask : chk
  // serial clock levels held 4 to 5 sys cycles, slow enough for sync
  task automatic sp(input logic cs, input logic rd, input logic [12:0] a,
      input logic [7:0] d, output logic [7:0] q);
    logic [23:0] f;
    f = {rd, 2'b00, a, d};
    sel_n <= ~cs;
    for (int i = 23; i >= 0; i--) begin
      cyc(1);
      sclk <= 1'b0;
      sdi <= f[i];
      cyc(5);
      q[i % 8] = sdio;
      sclk <= 1'b1;
      cyc(3);
    end
    cyc(1);
    sclk <= 1'b0;
    cyc(5);
    sel_n <= 1'b1;
    cyc(6);
  endtask : sp
  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    logic [7:0] q;
    sp(1'b1, 1'b0, a, d, q);
  endtask : wr
  task automatic rdc(input logic [12:0] a, input logic [7:0] e);
    logic [7:0] q;
    sp(1'b1, 1'b1, a, 8'h00, q);
    chk($sformatf("reg %h", a), 64'(e), 64'(q));
  endtask : rdc
  // one sample, then three frames so the word has surely landed
  task automatic smp(output logic [63:0] w);
    logic [15:0] f0;
    cyc(1);
    sv <= 1'b1;
    cyc(1);
    sv <= 1'b0;
    f0 = fr;
    for (int t = 0; t < 400 && fr - f0 < 16'h3; t++) begin
      cyc(1);
    end
    if (fr - f0 < 16'h3) begin
      n_fail++;
      $display("Error frames expected 3 seen %0d", fr - f0);
      end_sim();
    end
    w = words;
  endtask : smp
  // two-word order may start on either word, except for pn
  task automatic pat(input logic [3:0] m, input logic [15:0] e1,
      input logic [15:0] e2, input logic [4:0] n);
    logic [63:0] a, b;
    wr(13'h000D, {4'h0, m});
    smp(a);
    smp(b);
    if (a[15:0] === e2 && m != 4'h5 && m != 4'h6) begin
      e2 = e1;
      e1 = a[15:0];
    end
    chk("first word", {4{e1}}, a);
    chk("second word", {4{e2}}, b);
    chk("frame bits", 64'(n), 64'(nb));
  endtask : pat
  initial begin
    logic [63:0] w;
    logic [7:0] q;
    cyc(6);
    rst_n <= 1'b1;
    cyc(8);
    chk("swing", 64'h1, 64'(rso));
    smp(w);
    chk("strap word", {4{16'h800}}, w);
    rdc(13'h0030, 8'h07);
    sp(1'b0, 1'b0, 13'h0019, 8'h5A, q);
    rdc(13'h0019, 8'h00);
    rs <= 1'b0;
    tp <= 1'b0;
    rst_n <= 1'b0;
    cyc(6);
    rst_n <= 1'b1;
    cyc(8);
    chk("swing", 64'h0, 64'(rso));
    $display("straps test done");
    for (int i = 25; i < 29; i++) begin
      rdc(13'(i), 8'h00);
    end
    rdc(13'h0005, 8'h00);
    rdc(13'h0016, 8'h03);
    wr(13'h0016, 8'h0C);
    rdc(13'h0016, 8'h03);
    wr(13'h0016, 8'h00);
    rdc(13'h0016, 8'h00);
    wr(13'h0016, 8'h03);
    wr(13'h0019, 8'h34);
    wr(13'h001A, 8'h12);
    wr(13'h001B, 8'hCD);
    wr(13'h001C, 8'hAB);
    rdc(13'h001A, 8'h12);
    $display("register test done");
    smp(w);
    chk("samples", 64'h0ABC078904560123, w);
    wr(13'h0014, 8'h01);
    smp(w);
    chk("twos samples", 64'h02BC0F890C560923, w);
    pat(4'h2, 16'h7FF, 16'h7FF, 5'hC);
    pat(4'h9, 16'hAAA, 16'hAAA, 5'hC);
    wr(13'h0014, 8'h00);
    $display("format test done");
    pat(4'h1, 16'h800, 16'h800, 5'hC);
    pat(4'h2, 16'hFFF, 16'hFFF, 5'hC);
    pat(4'h3, 16'h000, 16'h000, 5'hC);
    pat(4'h4, 16'hAAA, 16'h555, 5'hC);
    pat(4'h5, 16'h591, 16'hFD7, 5'hC);
    pat(4'h6, 16'hDF9, 16'h353, 5'hC);
    pat(4'h7, 16'hFFF, 16'h000, 5'hC);
    pat(4'h8, 16'h234, 16'hBCD, 5'hC);
    pat(4'h9, 16'hAAA, 16'hAAA, 5'hC);
    pat(4'hA, 16'h03F, 16'h03F, 5'hC);
    pat(4'hB, 16'h800, 16'h800, 5'hC);
    pat(4'hC, 16'hA33, 16'hA33, 5'hC);
    $display("pattern test done");
    wr(13'h0021, 8'h03);
    pat(4'hB, 16'h8000, 16'h8000, 5'h10);
    wr(13'h0021, 8'h01);
    pat(4'hC, 16'h0A3, 16'h0A3, 5'h8);
    wr(13'h0021, 8'h02);
    pat(4'hA, 16'h01F, 16'h01F, 5'hA);
    wr(13'h0021, 8'h04);
    pat(4'hC, 16'hCC5, 16'hCC5, 5'hC);
    wr(13'h0021, 8'h00);
    wr(13'h0014, 8'h04);
    pat(4'hB, 16'h7FF, 16'h7FF, 5'hC);
    $display("length test done");
    end_sim();
  end
endmodule : tb_top
`default_nettype wire
